// ==== hw/rck_device.sv ====
// Device end: return clock start, stop, phase timing and output shaping
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

// Functional notes
// - Core clock is data clock divided by four
// - Drive differential or single-ended clock when enabled
// - Mode reg nine bit 2 selects single-ended
// - Mode reg nine bit 3 selects half swing
// - High-Z to static before toggling, reverse after
// - Host sets enable latency long enough
// - Read mode: fast phase at RL-EN-LS
// - Start mode: fast phase at RL+spacing-EN-LS
// - All read flavours count as reads
// - Host keeps read-stop spacing in read mode and start-read spacing in start mode
// - Host keeps start-to-stop spacing in start mode
// - Host keeps stop-to-start spacing
// - Host stops clock before setting changes
module rck_device
  import rck_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  rck_link_if.device link,
  output logic      clock_running,
  output logic      fast_phase
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF, ST_STATIC, ST_SLOW, ST_FAST, ST_PARK
  } rck_state_t;

  rck_state_t      state_reg;
  rck_state_t      state_next;
  logic [1:0]      div_reg;
  logic            core_tick;
  logic [MR_W-1:0] mr9_reg;
  logic [MR_W-1:0] mode_reg_twelve_reg;
  logic [7:0]      wait_reg;
  logic [7:0]      wait_next;
  logic            level_reg;
  logic            level_next;
  logic            oe_next;
  logic            is_read;
  logic            trigger;
  logic            stop_req;
  logic [1:0]      start_mode;
  logic            single_ended;
  logic [7:0]      en_lat;
  logic [7:0]      slow_len;
  logic [7:0]      rd_lat;
  logic [9:0]      offset_sum;
  logic [9:0]      offset_sub;
  logic [7:0]      fast_offset;

  // ----------------------------------------------------------------
  // Core clock
  // ----------------------------------------------------------------
  // Divide by four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 2'd0;
    end else if (ce) begin
      div_reg <= div_reg + 2'd1;
    end
  end

  assign core_tick = ce && (div_reg == DIV_LAST);

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  // Settings are taken as they arrive; quiet spacing is the host's job
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mr9_reg  <= MR9_RESET;
      mode_reg_twelve_reg <= MODE_REG_TWELVE_RESET;
    end else if (ce && link.cmd_valid && link.cmd == CMD_MODE_WRITE) begin
      if (link.mr_addr == MR_ADDR_NINE) begin
        mr9_reg <= link.mr_data;
      end
      if (link.mr_addr == MR_ADDR_TWELVE) begin
        mode_reg_twelve_reg <= link.mr_data;
      end
    end
  end

  assign start_mode   = mr9_reg[MODE_LSB +: 2];
  assign single_ended = mr9_reg[TYPE_BIT];
  assign en_lat       = {4'h0, mr9_reg[EN_LSB +: 4]};
  assign slow_len     = {4'h0, mr9_reg[LS_LSB +: 4]};
  assign rd_lat       = {2'b00, mode_reg_twelve_reg[RL_LSB +: 6]};

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Every read flavour
  always_comb begin
    unique case (link.cmd)
      CMD_READ, CMD_READ_AP, CMD_INFO_READ,
      CMD_READ_TRAIN, CMD_WTEC_READ: is_read = 1'b1;
      default:                       is_read = 1'b0;
    endcase
  end

  assign trigger = link.cmd_valid && state_reg == ST_OFF &&
                   ((start_mode == MODE_ON_READ && is_read) ||
                    (start_mode == MODE_ON_START && link.cmd == CMD_START));
  assign stop_req = link.cmd_valid && link.cmd == CMD_STOP;

  // ----------------------------------------------------------------
  // Fast phase offset
  // ----------------------------------------------------------------
  // Read mode offset, plus start-to-read spacing in start mode
  always_comb begin
    offset_sum = {2'b00, rd_lat};
    if (start_mode == MODE_ON_START) begin
      offset_sum = offset_sum + {2'b00, START_TO_READ_NCK};
    end
    offset_sub = {2'b00, en_lat} + {2'b00, slow_len};
    if (offset_sum > offset_sub) begin
      fast_offset = 8'(offset_sum - offset_sub);
    end else begin
      fast_offset = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    if (core_tick && wait_reg != 8'h00) begin
      wait_next = wait_reg - 8'h01;
    end
    unique case (state_reg)
      ST_OFF: begin
        // Leave high-Z at a static level first
        if (trigger) begin
          state_next = ST_STATIC;
          wait_next  = fast_offset;
        end
      end
      ST_STATIC: begin
        if (stop_req) begin
          state_next = ST_PARK;
          wait_next  = STATIC_TO_HIZ_NCK;
        end else if (core_tick && wait_reg <= slow_len) begin
          state_next = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (stop_req) begin
          state_next = ST_PARK;
          wait_next  = STATIC_TO_HIZ_NCK;
        end else if (core_tick && wait_reg <= 8'h01) begin
          state_next = ST_FAST;
        end
      end
      ST_FAST: begin
        if (stop_req) begin
          state_next = ST_PARK;
          wait_next  = STATIC_TO_HIZ_NCK;
        end
      end
      ST_PARK: begin
        // Static level held before returning to high-Z
        if (core_tick && wait_reg <= 8'h01) begin
          state_next = ST_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_OFF;
      wait_reg  <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
    end
  end

  // ----------------------------------------------------------------
  // Output shaping
  // ----------------------------------------------------------------
  // Slow phase toggles at core rate, fast phase every data clock
  always_comb begin
    level_next = 1'b0;
    oe_next    = state_next != ST_OFF;
    if (state_next == ST_SLOW && state_reg == ST_SLOW) begin
      level_next = core_tick ? ~level_reg : level_reg;
    end else if (state_next == ST_FAST) begin
      level_next = ~level_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_reg           <= 1'b0;
      link.rck_true_o     <= 1'b0;
      link.rck_true_oe    <= 1'b0;
      link.rck_comp_o     <= 1'b0;
      link.rck_comp_oe    <= 1'b0;
      link.rck_half_swing <= 1'b0;
      clock_running       <= 1'b0;
      fast_phase          <= 1'b0;
    end else if (ce) begin
      level_reg        <= level_next;
      // True pin always, complement only when differential
      link.rck_true_o  <= level_next;
      link.rck_true_oe <= oe_next;
      link.rck_comp_o  <= ~level_next & ~single_ended;
      link.rck_comp_oe <= oe_next & ~single_ended;
      link.rck_half_swing <= mr9_reg[LEVEL_BIT];
      clock_running       <= oe_next;
      fast_phase          <= state_next == ST_FAST;
    end
  end

endmodule : rck_device

// ==== hw/rck_host.sv ====
// Controller end: AHB-Lite command port and return clock spacing
`timescale 1ns/1ps
module rck_host
  import rck_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  rck_link_if.host         link
);

  logic            wr_pend_reg;
  logic [7:0]      addr_reg;
  logic            pend_reg;
  link_cmd_t       pend_cmd_reg;
  logic [3:0]      pend_addr_reg;
  logic [MR_W-1:0] pend_data_reg;
  logic [1:0]      mode_reg;
  logic            running_reg;
  logic [9:0]      since_start_reg;
  logic [9:0]      since_stop_reg;
  logic [9:0]      since_read_reg;
  logic            is_read;
  logic            stop_ok;
  logic            go;
  logic            send_stop;
  logic [MR_W-1:0] mr_out;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      hrdata      <= WORD_ZERO;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (ce) begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      addr_reg    <= haddr[7:0];
      hrdata      <= WORD_ZERO;
      if (hsel && hready && htrans[1] && !hwrite &&
          haddr[7:0] == REG_STATUS_OFFSET) begin
        hrdata <= {28'h000_0000, mode_reg, running_reg, pend_reg};
      end
    end
  end

  // ----------------------------------------------------------------
  // Spacing checks, hclk counts of core cycles
  // ----------------------------------------------------------------
  assign is_read = pend_cmd_reg inside {CMD_READ, CMD_READ_AP, CMD_INFO_READ,
                                        CMD_READ_TRAIN, CMD_WTEC_READ};

  always_comb begin
    // Read to stop in read mode
    // Start to stop in start mode
    stop_ok = !running_reg ||
              (mode_reg == MODE_ON_READ &&
               since_read_reg >= 10'(READ_TO_STOP_NCK * CORE_DIV)) ||
              (mode_reg == MODE_ON_START &&
               since_start_reg >= 10'(START_TO_STOP_NCK * CORE_DIV));
    send_stop = 1'b0;
    go        = 1'b0;
    if (pend_reg) begin
      unique case (pend_cmd_reg)
        CMD_START: go = mode_reg != MODE_ON_START || running_reg ||
                        since_stop_reg >= 10'(STOP_TO_START_NCK * CORE_DIV);
        CMD_STOP: go = stop_ok;
        CMD_MODE_WRITE: begin
          // Stop first, then wait before the setting change
          if ((pend_addr_reg == MR_ADDR_NINE || pend_addr_reg == MR_ADDR_TWELVE)
              && running_reg) begin
            send_stop = stop_ok;
          end else begin
            go = since_stop_reg >= 10'(STOP_TO_SET_NCK * CORE_DIV);
          end
        end
        default: begin
          if (is_read && mode_reg == MODE_ON_READ && !running_reg) begin
            // A starting read also waits after stop
            go = since_stop_reg >= 10'(STOP_TO_START_NCK * CORE_DIV);
          end else if (is_read && mode_reg == MODE_ON_START && running_reg) begin
            go = since_start_reg >= 10'(START_TO_READ_NCK * CORE_DIV);
          end else begin
            go = 1'b1;
          end
        end
      endcase
    end
    mr_out = pend_data_reg;
    // Enable latency raised to a safe floor
    if (pend_addr_reg == MR_ADDR_NINE && mr_out[EN_LSB +: 4] < EN_LATENCY_MIN) begin
      mr_out[EN_LSB +: 4] = EN_LATENCY_MIN;
    end
  end

  // ----------------------------------------------------------------
  // Pending command and link drive
  // ----------------------------------------------------------------
  // Writes while a command waits are dropped; software polls busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg      <= 1'b0;
      pend_cmd_reg  <= CMD_NOP;
      pend_addr_reg <= 4'h0;
      pend_data_reg <= MR9_RESET;
    end else if (ce) begin
      if (go) begin
        pend_reg <= 1'b0;
      end else if (wr_pend_reg && addr_reg == REG_CMD_OFFSET && !pend_reg) begin
        pend_reg      <= 1'b1;
        pend_cmd_reg  <= link_cmd_t'(hwdata[3:0]);
        pend_addr_reg <= hwdata[7:4];
        pend_data_reg <= hwdata[19:8];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cmd_valid <= 1'b0;
      link.cmd       <= CMD_NOP;
      link.mr_addr   <= 4'h0;
      link.mr_data   <= MR9_RESET;
    end else if (ce) begin
      link.cmd_valid <= go || send_stop;
      link.cmd       <= send_stop ? CMD_STOP : (go ? pend_cmd_reg : CMD_NOP);
      link.mr_addr   <= pend_addr_reg;
      link.mr_data   <= mr_out;
    end
  end

  // ----------------------------------------------------------------
  // Shadow of the device's start state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg        <= MODE_OFF;
      running_reg     <= 1'b0;
      since_start_reg <= 10'h3FF;
      since_stop_reg  <= 10'h3FF;
      since_read_reg  <= 10'h3FF;
    end else if (ce) begin
      since_start_reg <= since_start_reg + {9'h000, since_start_reg != 10'h3FF};
      since_stop_reg  <= since_stop_reg + {9'h000, since_stop_reg != 10'h3FF};
      since_read_reg  <= since_read_reg + {9'h000, since_read_reg != 10'h3FF};
      if (send_stop || (go && pend_cmd_reg == CMD_STOP)) begin
        running_reg    <= 1'b0;
        since_stop_reg <= 10'h000;
      end else if (go && pend_cmd_reg == CMD_START && mode_reg == MODE_ON_START) begin
        running_reg     <= 1'b1;
        since_start_reg <= 10'h000;
      end else if (go && is_read) begin
        since_read_reg <= 10'h000;
        if (mode_reg == MODE_ON_READ) begin
          running_reg <= 1'b1;
        end
      end else if (go && pend_cmd_reg == CMD_MODE_WRITE && pend_addr_reg == MR_ADDR_NINE) begin
        mode_reg <= mr_out[MODE_LSB +: 2];
      end
    end
  end

endmodule : rck_host

// ==== include/rck_link_if.sv ====
// Link between the memory controller end and the device end
`timescale 1ns/1ps
interface rck_link_if
  import rck_pkg::*;
(
  input wire logic hclk
);
  logic            cmd_valid;
  link_cmd_t       cmd;
  logic [3:0]      mr_addr;
  logic [MR_W-1:0] mr_data;
  logic            rck_true_o;
  logic            rck_true_oe;
  logic            rck_comp_o;
  logic            rck_comp_oe;
  logic            rck_half_swing;

  modport device (
    input  cmd_valid, cmd, mr_addr, mr_data,
    output rck_true_o, rck_true_oe, rck_comp_o, rck_comp_oe, rck_half_swing
  );
  modport host (
    output cmd_valid, cmd, mr_addr, mr_data,
    input  rck_true_o, rck_true_oe, rck_comp_o, rck_comp_oe, rck_half_swing
  );
endinterface : rck_link_if

// ==== include/rck_pkg.sv ====
// Shared constants and types for the return clock control ends
package rck_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int unsigned CORE_DIV = 4;
  localparam logic [1:0]  DIV_LAST = 2'd3;

  // ----------------------------------------------------------------
  // Link commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP, CMD_READ, CMD_READ_AP, CMD_INFO_READ, CMD_READ_TRAIN,
    CMD_WTEC_READ, CMD_START, CMD_STOP, CMD_MODE_WRITE
  } link_cmd_t;

  // ----------------------------------------------------------------
  // Mode register layout
  // ----------------------------------------------------------------
  localparam int         MR_W          = 12;
  localparam logic [3:0] MR_ADDR_NINE  = 4'h9;
  localparam logic [3:0] MR_ADDR_TWELVE = 4'hC;
  localparam int         MODE_LSB      = 0;
  localparam int         TYPE_BIT      = 2;
  localparam int         LEVEL_BIT     = 3;
  localparam int         EN_LSB        = 4;
  localparam int         LS_LSB        = 8;
  localparam int         RL_LSB        = 0;
  localparam logic [1:0] MODE_OFF      = 2'b00;
  localparam logic [1:0] MODE_ON_READ  = 2'b01;
  localparam logic [1:0] MODE_ON_START = 2'b10;
  localparam logic [MR_W-1:0] MR9_RESET  = 12'h000;
  localparam logic [MR_W-1:0] MODE_REG_TWELVE_RESET = 12'h010;

  // ----------------------------------------------------------------
  // Timing, in core clock cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] START_TO_READ_NCK  = 8'h04;
  localparam logic [7:0] READ_TO_STOP_NCK   = 8'h04;
  localparam logic [7:0] START_TO_STOP_NCK  = 8'h0A;
  localparam logic [7:0] STOP_TO_START_NCK  = 8'h04;
  localparam logic [7:0] STOP_TO_SET_NCK    = 8'h08;
  localparam logic [7:0] STATIC_TO_HIZ_NCK  = 8'h02;
  localparam logic [3:0] EN_LATENCY_MIN     = 4'h2;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CMD_OFFSET    = 8'h00;
  localparam logic [7:0]  REG_STATUS_OFFSET = 8'h04;
  localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;

endpackage : rck_pkg

// ==== sim/rck_link_asserts.sv ====
// Concurrent checks on the link between the controller end and the device end
`timescale 1ns/1ps
module rck_link_asserts
  import rck_pkg::*;
(
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            cmd_valid,
  input wire link_cmd_t       cmd,
  input wire logic [3:0]      mr_addr,
  input wire logic [MR_W-1:0] mr_data,
  input wire logic            rck_true_o,
  input wire logic            rck_true_oe,
  input wire logic            rck_comp_o,
  input wire logic            rck_comp_oe,
  input wire logic            rck_half_swing
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic            is_rd;
  logic            is_st;
  logic            is_sp;
  logic            is_mw;
  logic [7:0]      since_st;
  logic [7:0]      since_sp;
  logic [7:0]      since_rd;
  logic [7:0]      low_run;
  logic [MR_W-1:0] nine_reg;

  assign is_rd = cmd_valid && (cmd inside {[CMD_READ:CMD_WTEC_READ]});
  assign is_st = cmd_valid && cmd == CMD_START;
  assign is_sp = cmd_valid && cmd == CMD_STOP;
  assign is_mw = cmd_valid && cmd == CMD_MODE_WRITE
                 && (mr_addr == MR_ADDR_NINE || mr_addr == MR_ADDR_TWELVE);

  // Start saturated, so nothing is owed right after reset
  function automatic logic [7:0] age(input logic hit, input logic [7:0] c);
    return hit ? 8'h00 : ((c == 8'hff) ? c : c + 8'h01);
  endfunction : age

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_st <= 8'hff;
      since_sp <= 8'hff;
      since_rd <= 8'hff;
      low_run  <= 8'h00;
      nine_reg <= MR9_RESET;
    end else begin
      since_st <= age(is_st, since_st);
      since_sp <= age(is_sp, since_sp);
      since_rd <= age(is_rd, since_rd);
      low_run  <= age(!rck_true_oe || rck_true_o, low_run);
      if (is_mw && mr_addr == MR_ADDR_NINE) begin
        nine_reg <= mr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_wake;
    $rose(rck_true_oe);
  endsequence
  sequence s_release;
    $fell(rck_true_oe);
  endsequence

  property p_comp_inverse;
    rck_comp_oe |-> rck_comp_o == !rck_true_o;
  endproperty
  property p_comp_with_true;
    rck_comp_oe |-> rck_true_oe;
  endproperty
  property p_single_ended;
    nine_reg[TYPE_BIT] |-> !rck_comp_oe;
  endproperty
  property p_half_swing;
    !$past(cmd_valid) |-> rck_half_swing == nine_reg[LEVEL_BIT];
  endproperty
  property p_wake_static;
    s_wake |-> !rck_true_o;
  endproperty
  property p_park_low;
    s_release |-> low_run >= 8'h04;
  endproperty
  property p_start_to_read;
    is_rd |-> since_st >= 4 * START_TO_READ_NCK - 4;
  endproperty
  property p_read_to_stop;
    is_sp |-> since_rd >= 4 * READ_TO_STOP_NCK - 4;
  endproperty
  property p_start_to_stop;
    is_sp |-> since_st >= 4 * START_TO_STOP_NCK - 4;
  endproperty
  property p_stop_to_start;
    is_st |-> since_sp >= 4 * STOP_TO_START_NCK - 4;
  endproperty
  property p_stop_to_mode;
    is_mw |-> since_sp >= 4 * STOP_TO_SET_NCK - 4;
  endproperty

  a_comp_inverse: assert property (p_comp_inverse) else $error("comp not inverse");
  a_comp_with_true: assert property (p_comp_with_true) else $error("comp alone");
  a_single_ended: assert property (p_single_ended) else $error("comp in single");
  a_half_swing: assert property (p_half_swing) else $error("swing mismatch");
  a_wake_static: assert property (p_wake_static) else $error("no static wake");
  a_park_low: assert property (p_park_low) else $error("no static park");
  a_start_to_read: assert property (p_start_to_read) else $error("early read");
  a_read_to_stop: assert property (p_read_to_stop) else $error("stop after read");
  a_start_to_stop: assert property (p_start_to_stop) else $error("stop after start");
  a_stop_to_start: assert property (p_stop_to_start) else $error("start after stop");
  a_stop_to_mode: assert property (p_stop_to_mode) else $error("mode after stop");
endmodule : rck_link_asserts

// ==== sim/test_read_clock_output_control.sv ====
// Self-checking bench: controller and device ends joined over the link
`timescale 1ns/1ps
module test_read_clock_output_control
  import rck_pkg::*;
;
  localparam int LS  = 3;
  localparam int EN  = 2;
  localparam int RL0 = 16;

  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        clock_running;
  logic        fast_phase;
  logic [31:0] q;
  logic        snap;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          trig_cyc  = 0;

  assign hready = hreadyout;

  rck_link_if link (.hclk(hclk));

  rck_host rck_host_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link)
  );

  rck_device rck_device_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .link(link),
    .clock_running(clock_running), .fast_phase(fast_phase)
  );

  rck_link_asserts rck_link_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .cmd_valid(link.cmd_valid), .cmd(link.cmd),
    .mr_addr(link.mr_addr), .mr_data(link.mr_data), .rck_true_o(link.rck_true_o),
    .rck_true_oe(link.rck_true_oe), .rck_comp_o(link.rck_comp_o),
    .rck_comp_oe(link.rck_comp_oe), .rck_half_swing(link.rck_half_swing)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Phase offset is measured from the edge that takes the trigger
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (link.cmd_valid === 1'b1 && link.rck_true_oe !== 1'b1 &&
        link.cmd inside {[CMD_READ:CMD_START]}) begin
      trig_cyc <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_span(input int got, input int lo, input int hi, input string what);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_span

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  // Polls pending first, since a command written while busy is dropped
  task automatic issue(input link_cmd_t c, input logic [3:0] a, input logic [11:0] d);
    int n = 0;
    do begin
      ahb(1'b0, REG_STATUS_OFFSET, WORD_ZERO);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    ahb(1'b1, REG_CMD_OFFSET, {12'h000, d, a, c});
  endtask : issue

  task automatic wait_run(input logic lvl);
    int n = 0;
    while (clock_running !== lvl && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, clock_running}, {31'h0, lvl}, "clock running");
  endtask : wait_run

  task automatic check_fast(input int w);
    int n = 0;
    while (fast_phase !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk_span(cyc - trig_cyc, 4 * w - 7, 4 * w + 4, "fast offset");
  endtask : check_fast

  task automatic stop_clock;
    issue(CMD_STOP, 4'h0, 12'h000);
    wait_run(1'b0);
    chk({30'h0, link.rck_true_oe, link.rck_comp_oe}, 32'h0, "oe");
    repeat (4 * STOP_TO_START_NCK) @(posedge hclk);
  endtask : stop_clock

  function automatic logic [11:0] nine(input logic [1:0] m, input logic se, input logic hs);
    return {4'h3, 4'h2, hs, se, m};
  endfunction : nine

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    end_of_test();
  end

  initial begin
    hresetn = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b0;
    haddr   = WORD_ZERO;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b000;
    hwdata  = WORD_ZERO;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk({30'h0, hreadyout, hresp}, 32'h2, "bus idle");
    chk({31'h0, link.rck_true_oe}, 32'h0, "oe reset");
    ahb(1'b0, REG_STATUS_OFFSET, WORD_ZERO);
    chk(q, WORD_ZERO, "status reset");
    ahb(1'b1, 8'h08, 32'hffff_ffff);
    ahb(1'b0, 8'h08, WORD_ZERO);
    chk(q, WORD_ZERO, "unmapped");
    issue(CMD_READ, 4'h0, 12'h000);
    repeat (100) @(posedge hclk);
    chk({31'h0, clock_running}, 32'h0, "read, mode off");
    issue(CMD_MODE_WRITE, MR_ADDR_NINE, nine(MODE_ON_READ, 1'b0, 1'b0));
    ahb(1'b0, REG_STATUS_OFFSET, WORD_ZERO);
    chk(q & 32'h0000_000c, 32'h0000_0004, "start mode field");
    for (int i = 1; i <= 5; i++) begin
      issue(link_cmd_t'(i), 4'h0, 12'h000);
      check_fast(RL0 - EN - LS);
      chk({31'h0, link.rck_comp_oe}, 32'h1, "differential");
      ahb(1'b0, REG_STATUS_OFFSET, WORD_ZERO);
      chk(q & 32'h0000_0002, 32'h0000_0002, "status running");
      stop_clock();
    end
    issue(CMD_START, 4'h0, 12'h000);
    repeat (100) @(posedge hclk);
    chk({31'h0, clock_running}, 32'h0, "start in read mode");
    issue(CMD_MODE_WRITE, MR_ADDR_NINE, nine(MODE_ON_START, 1'b0, 1'b0));
    issue(CMD_READ, 4'h0, 12'h000);
    repeat (100) @(posedge hclk);
    chk({31'h0, clock_running}, 32'h0, "read in start mode");
    issue(CMD_START, 4'h0, 12'h000);
    check_fast(RL0 + START_TO_READ_NCK - EN - LS);
    issue(CMD_READ, 4'h0, 12'h000);
    repeat (40) @(posedge hclk);
    stop_clock();
    issue(CMD_MODE_WRITE, MR_ADDR_TWELVE, 12'h014);
    issue(CMD_MODE_WRITE, MR_ADDR_NINE, nine(MODE_ON_READ, 1'b1, 1'b1));
    // Write lands two edges after the bus, swing one more
    repeat (6) @(posedge hclk);
    chk({31'h0, link.rck_half_swing}, 32'h1, "half swing");
    issue(CMD_READ_AP, 4'h0, 12'h000);
    check_fast(20 - EN - LS);
    chk({30'h0, link.rck_true_oe, link.rck_comp_oe}, 32'h2, "single");
    @(posedge hclk);
    ce <= 1'b0;
    @(posedge hclk);
    snap = link.rck_true_o;
    repeat (8) @(posedge hclk);
    chk({31'h0, link.rck_true_o}, {31'h0, snap}, "frozen clock");
    ce <= 1'b1;
    // Setting change while running: the controller has to stop first
    issue(CMD_MODE_WRITE, MR_ADDR_NINE, nine(MODE_ON_READ, 1'b0, 1'b0));
    wait_run(1'b0);
    repeat (4 * STOP_TO_SET_NCK + 20) @(posedge hclk);
    chk({31'h0, link.rck_half_swing}, 32'h0, "full swing");
    end_of_test();
  end
endmodule : test_read_clock_output_control
